/* hdl/fault_flags.sv */
// two sticky write-one-to-clear fault flags
`timescale 1ns/1ps
`default_nettype none
module fault_flags (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // set and clear per flag
  input wire logic [1:0] set_i,
  input wire logic [1:0] clr_i,
  // flags
  output logic [1:0] flags_o
);

  logic [1:0] flags_r;

  for (genvar b = 0; b < 2; b++) begin : g_flag
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        flags_r[b] <= 1'b0;
      end else if (set_i[b]) begin
        flags_r[b] <= 1'b1;
      end else if (clr_i[b]) begin
        flags_r[b] <= 1'b0;
      end
    end
  end

  assign flags_o = flags_r;

  a_set_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (set_i & clr_i) != 2'b00 |=> (flags_r & $past(set_i & clr_i)) == $past(set_i & clr_i))
    else $error("flag lost on same-cycle set and clear");
  a_clear_only_one: assert property (@(posedge clk_i) disable iff (!resetn_i)
    clr_i[0] && !set_i[0] |=> !flags_r[0])
    else $error("single-fault flag not cleared by written one");

endmodule // fault_flags
`default_nettype wire

/* hdl/flash_fault_and_protection_regs.sv */
// fault status and flash protection registers behind an apb slave
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_defs.svh"
module flash_fault_and_protection_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // nonvolatile protection byte, valid while reset is released
  input wire logic [7:0] nv_prot_byte_i,
  // array read events from the flash read path
  input wire flash_prot_pkg::rd_evt_s rd_evt_i,
  // command requests from the sequencer
  input wire logic cmd_req_i,
  input wire flash_prot_pkg::cmd_s cmd_i,
  output logic cmd_grant_o,
  output logic cmd_refuse_o,
  // status towards the sequencer
  output logic prot_viol_o
);

  flash_prot_pkg::boot_state_e state_r;
  logic [7:0] prot_r;
  logic [7:0] prot_nxt;
  logic [7:0] config_r;
  logic pviol_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic grant_r;
  logic refuse_r;
  logic [1:0] fault_flags_w;
  logic [1:0] fault_set;
  logic [1:0] fault_clr;
  flash_prot_pkg::sector_map_t cur_map;
  flash_prot_pkg::sector_map_t cand_map;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic acc;
  logic aligned;
  logic hit_fault;
  logic hit_prot;
  logic hit_config;
  logic hit_status;
  logic hit_any;
  logic wr_take;

  assign acc = psel_i & penable_i;
  assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
  assign hit_fault = aligned && (paddr_i[9:2] == `IDX_FAULT_STATUS);
  assign hit_prot = aligned && (paddr_i[9:2] == `IDX_SECTOR_PROTECT);
  assign hit_config = aligned && (paddr_i[9:2] == `IDX_FLASH_CONFIG);
  assign hit_status = aligned && (paddr_i[9:2] == `IDX_FLASH_STATUS);
  assign hit_any = hit_fault | hit_prot | hit_config | hit_status;

  // one wait state: the answer registers, then the write lands on the
  // edge where the master samples pready high
  assign wr_take = acc & pready_r & pwrite_i & hit_any;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= acc & !pready_r;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pslverr_r <= 1'b0;
    end else if (acc & !pready_r) begin
      pslverr_r <= !hit_any;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_fault) begin
      rdata_nxt[1:0] = fault_flags_w;
    end else if (hit_prot) begin
      rdata_nxt[7:0] = prot_r;
    end else if (hit_config) begin
      rdata_nxt[7:0] = config_r;
    end else if (hit_status) begin
      rdata_nxt[`BIT_PROT_VIOL] = pviol_r;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (acc & !pready_r & !pwrite_i) begin
      prdata_r <= rdata_nxt;
    end else begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_r <= `RST_FLASH_CONFIG;
    end else if (wr_take && hit_config) begin
      config_r <= 8'h00;
      config_r[`BIT_IGNORE_SINGLE] <= pwdata_i[`BIT_IGNORE_SINGLE];
    end
  end

  // ------------------------------------------------------------
  // fault flags
  // ------------------------------------------------------------
  logic ignore_single;
  assign ignore_single = config_r[`BIT_IGNORE_SINGLE];

  // an uncorrectable error outranks a corrected one on the same read;
  // a collision marks both flags unless single faults are ignored
  assign fault_set[`BIT_DOUBLE_FAULT] = rd_evt_i.valid & (rd_evt_i.dbe | rd_evt_i.collision);
  assign fault_set[`BIT_SINGLE_FAULT] = rd_evt_i.valid & !ignore_single &
    ((rd_evt_i.sbe & !rd_evt_i.dbe) | rd_evt_i.collision);
  // bits 7..2 have no storage, so writes there vanish
  assign fault_clr = (wr_take && hit_fault) ? pwdata_i[1:0] : 2'b00;

  // flags register on the edge after the read, visible one cycle later
  fault_flags u_fault_flags (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .set_i(fault_set),
    .clr_i(fault_clr),
    .flags_o(fault_flags_w)
  );

  // ------------------------------------------------------------
  // protection register
  // ------------------------------------------------------------
  prot_region u_cur_region (
    .prot_i(prot_r),
    .map_o(cur_map)
  );

  // candidate value: size fields only move while their range is disabled
  always_comb begin
    prot_nxt = prot_r;
    prot_nxt[`BIT_POLARITY] = pwdata_i[`BIT_POLARITY];
    prot_nxt[`BIT_HIGH_DISABLE] = pwdata_i[`BIT_HIGH_DISABLE];
    prot_nxt[`BIT_LOW_DISABLE] = pwdata_i[`BIT_LOW_DISABLE];
    if (prot_r[`BIT_HIGH_DISABLE]) begin
      prot_nxt[`BIT_HIGH_SIZE_HI:`BIT_HIGH_SIZE_LO] =
        pwdata_i[`BIT_HIGH_SIZE_HI:`BIT_HIGH_SIZE_LO];
    end
    if (prot_r[`BIT_LOW_DISABLE]) begin
      prot_nxt[`BIT_LOW_SIZE_HI:`BIT_LOW_SIZE_LO] =
        pwdata_i[`BIT_LOW_SIZE_HI:`BIT_LOW_SIZE_LO];
    end
  end

  prot_region u_cand_region (
    .prot_i(prot_nxt),
    .map_o(cand_map)
  );

  // checked per sector, so a polarity flip that keeps coverage is legal
  logic prot_grows;
  assign prot_grows = ((cur_map & ~cand_map) == 16'h0000);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= flash_prot_pkg::ST_LOAD;
    end else begin
      state_r <= flash_prot_pkg::ST_RUN;
    end
  end

  // the nonvolatile byte is taken on the first edge after release;
  // bit 6 keeps whatever the image holds, software cannot touch it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prot_r <= `RST_SECTOR_PROTECT;
    end else if (state_r == flash_prot_pkg::ST_LOAD) begin
      prot_r <= nv_prot_byte_i;
    end else if (wr_take && hit_prot && prot_grows) begin
      prot_r <= prot_nxt;
    end
  end

  // ------------------------------------------------------------
  // command screening
  // ------------------------------------------------------------
  logic addr_prot;
  logic cmd_hits_prot;
  logic cmd_ok;
  assign addr_prot = cur_map[cmd_i.addr[`SECTOR_MSB:`SECTOR_LSB]];

  always_comb begin
    unique case (cmd_i.kind)
      flash_prot_pkg::CMD_SEQ_START: cmd_hits_prot = 1'b0;
      flash_prot_pkg::CMD_PROGRAM: cmd_hits_prot = addr_prot;
      flash_prot_pkg::CMD_ERASE_SECTOR: cmd_hits_prot = addr_prot;
      flash_prot_pkg::CMD_ERASE_BLOCK: cmd_hits_prot = |cur_map;
    endcase
  end

  // nothing launches before the protection byte is in place
  assign cmd_ok = (state_r == flash_prot_pkg::ST_RUN) && !pviol_r && !cmd_hits_prot;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      grant_r <= 1'b0;
      refuse_r <= 1'b0;
    end else begin
      grant_r <= cmd_req_i & cmd_ok;
      refuse_r <= cmd_req_i & !cmd_ok;
    end
  end

  // a violation is only raised by a fresh attempt, not by one refused
  // because the flag already stands
  logic pviol_set;
  logic pviol_clr;
  assign pviol_set = cmd_req_i && (state_r == flash_prot_pkg::ST_RUN) &&
    !pviol_r && cmd_hits_prot;
  assign pviol_clr = wr_take && hit_status && pwdata_i[`BIT_PROT_VIOL];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pviol_r <= 1'b0;
    end else if (pviol_set) begin
      pviol_r <= 1'b1;
    end else if (pviol_clr) begin
      pviol_r <= 1'b0;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign cmd_grant_o = grant_r;
  assign cmd_refuse_o = refuse_r;
  assign prot_viol_o = pviol_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence seq_prot_hit;
    cmd_req_i && state_r == flash_prot_pkg::ST_RUN && !pviol_r && cmd_hits_prot;
  endsequence

  sequence seq_refused_viol;
    cmd_refuse_o && !cmd_grant_o && prot_viol_o;
  endsequence

  sequence seq_fault_read;
    acc && !pready_r && !pwrite_i && hit_fault;
  endsequence

  sequence seq_apb_first;
    acc && !pready_r;
  endsequence

  a_resv_zero: assert property (seq_fault_read |=> prdata_o[31:2] == 30'h0)
    else $error("reserved fault status bits not zero");
  a_double_set: assert property (rd_evt_i.valid && rd_evt_i.dbe |=>
    fault_flags_w[`BIT_DOUBLE_FAULT])
    else $error("double-fault flag missed");
  a_double_hold: assert property (fault_flags_w[1] && !fault_clr[1] |=>
    fault_flags_w[1])
    else $error("double-fault flag dropped without a written one");
  a_single_set: assert property (rd_evt_i.valid && rd_evt_i.sbe && !rd_evt_i.dbe &&
    !ignore_single |=> fault_flags_w[0])
    else $error("single-fault flag missed");
  a_ecc_exclusive: assert property (rd_evt_i.valid && rd_evt_i.dbe &&
    !rd_evt_i.collision && !fault_flags_w[0] |=> !fault_flags_w[0])
    else $error("both flags raised for one ecc event");
  a_flag_delay: assert property ($rose(fault_flags_w[1]) |->
    $past(rd_evt_i.valid && (rd_evt_i.dbe || rd_evt_i.collision)))
    else $error("double-fault flag not one cycle after its read");
  a_no_shrink: assert property (state_r == flash_prot_pkg::ST_RUN &&
    $past(state_r) == flash_prot_pkg::ST_RUN |-> ($past(cur_map) & ~cur_map) == 16'h0)
    else $error("protected region shrank");
  a_boot_load: assert property (state_r == flash_prot_pkg::ST_LOAD |=>
    prot_r == $past(nv_prot_byte_i))
    else $error("protection byte not loaded after reset");
  a_viol_refuse: assert property (seq_prot_hit |=> seq_refused_viol)
    else $error("protected command not refused with violation");
  a_high_lock: assert property (state_r == flash_prot_pkg::ST_RUN &&
    !prot_r[`BIT_HIGH_DISABLE] |=> prot_r[4:3] == $past(prot_r[4:3]))
    else $error("higher size field changed while range enabled");
  a_low_lock: assert property (state_r == flash_prot_pkg::ST_RUN &&
    !prot_r[`BIT_LOW_DISABLE] |=> prot_r[1:0] == $past(prot_r[1:0]))
    else $error("lower size field changed while range enabled");
  a_viol_block: assert property (pviol_r && cmd_req_i |=> cmd_refuse_o && !cmd_grant_o)
    else $error("command passed while violation flag set");
  a_ready_next: assert property (seq_apb_first |=> pready_o ##1 !pready_o)
    else $error("apb answer not a single pulse after one wait state");
  a_err_unmapped: assert property (acc && !pready_r && !hit_any |=> pready_o && pslverr_o)
    else $error("unmapped access not answered with an error");
  a_single_hold: assert property (fault_flags_w[0] && !fault_clr[0] |=>
    fault_flags_w[0])
    else $error("single-fault flag dropped without a written one");
  a_double_clear: assert property (fault_clr[1] && !fault_set[1] |=>
    !fault_flags_w[1])
    else $error("double-fault flag not cleared by written one");
  a_coll_both: assert property (rd_evt_i.valid && rd_evt_i.collision &&
    !ignore_single |=> fault_flags_w == 2'b11)
    else $error("collision did not raise both flags");
  a_single_ignore: assert property (rd_evt_i.valid && !rd_evt_i.dbe && ignore_single &&
    !fault_flags_w[0] |=> !fault_flags_w[0])
    else $error("single-fault flag raised while ignored");
  a_viol_hold: assert property (pviol_r && !pviol_clr |=> pviol_r)
    else $error("violation flag dropped without a written one");
  a_viol_clear: assert property (pviol_clr && !pviol_set |=> !pviol_r)
    else $error("violation flag not cleared by written one");
  a_block_erase: assert property (cmd_req_i && (|cur_map) &&
    cmd_i.kind == flash_prot_pkg::CMD_ERASE_BLOCK |=> cmd_refuse_o && !cmd_grant_o)
    else $error("block erase granted over a protected sector");
  a_grant_clean: assert property (cmd_grant_o |->
    !$past(cmd_hits_prot) && !$past(pviol_r))
    else $error("command granted on a protected address");
  a_reject_keep: assert property (state_r == flash_prot_pkg::ST_RUN && wr_take &&
    hit_prot && !prot_grows |=> $stable(prot_r))
    else $error("shrinking protection write took effect");
  a_accept_write: assert property (state_r == flash_prot_pkg::ST_RUN && wr_take &&
    hit_prot && prot_grows |=> prot_r == $past(prot_nxt))
    else $error("growing protection write lost");
  a_high_write: assert property (state_r == flash_prot_pkg::ST_RUN && wr_take &&
    hit_prot && prot_grows && prot_r[5] |=> prot_r[4:3] == $past(pwdata_i[4:3]))
    else $error("higher size field not written while range disabled");

endmodule // flash_fault_and_protection_regs
`default_nettype wire

/* hdl/flash_prot_defs.svh */
// constants for the flash fault and protection register block
// Operation
// - fault status bits 7..2 read as zero and ignore writes
// - double-fault flag sets on uncorrectable read or read of busy block
// - double-fault flag clears only on a written one
// - single-fault flag sets on corrected read or collision unless ignored
// - single-fault flag clears only on a written one
// - ecc event raises one flag only; collision raises both unless single faults are ignored
// - flags update one clock after the read; software waits one instruction
// - protection writes accepted only if protected region does not shrink
// - protection register loads from nonvolatile byte at reset
// - program or erase of protected address refused, violation flag set
// - block erase refused while any sector is protected
// - bit 7 polarity: 0 ranges unprotected, 1 ranges protected
// - bit 5 disables the higher range ending at 0x7fff
// - higher size field writable only while higher disable is set
// - bit 2 disables the lower range starting at 0x0_0000
// - lower size field writable only while lower disable is set
// - while violation flag set, no launch and no new sequence
`ifndef FLASH_PROT_DEFS_SVH
`define FLASH_PROT_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_FAULT_STATUS 8'h07
`define IDX_SECTOR_PROTECT 8'h08
`define IDX_FLASH_CONFIG 8'h10
`define IDX_FLASH_STATUS 8'h11

// field positions
`define BIT_DOUBLE_FAULT 1
`define BIT_SINGLE_FAULT 0
`define BIT_POLARITY 7
`define BIT_RESERVED_NV 6
`define BIT_HIGH_DISABLE 5
`define BIT_HIGH_SIZE_HI 4
`define BIT_HIGH_SIZE_LO 3
`define BIT_LOW_DISABLE 2
`define BIT_LOW_SIZE_HI 1
`define BIT_LOW_SIZE_LO 0
`define BIT_IGNORE_SINGLE 4
`define BIT_PROT_VIOL 4

// reset values
`define RST_SECTOR_PROTECT 8'hff
`define RST_FLASH_CONFIG 8'h00

// nonvolatile protection byte location
`define NV_PROT_ADDR 12'h40d

// flash geometry: 0x0_0000 .. 0x7fff in 16 sectors of 0x800
`define FLASH_ADDR_W 15
`define SECTOR_MSB 14
`define SECTOR_LSB 11
`define SECTOR_COUNT 16

// range size code to sector count
`define SIZE_CODE0 5'd1
`define SIZE_CODE1 5'd2
`define SIZE_CODE2 5'd4
`define SIZE_CODE3 5'd8

`endif

/* hdl/flash_prot_pkg.sv */
// types shared by the flash fault and protection block
package flash_prot_pkg;

  typedef enum logic [1:0] {
    CMD_SEQ_START = 2'b00,
    CMD_PROGRAM = 2'b01,
    CMD_ERASE_SECTOR = 2'b10,
    CMD_ERASE_BLOCK = 2'b11
  } cmd_kind_e;

  typedef struct packed {
    cmd_kind_e kind;
    logic [14:0] addr;
  } cmd_s;

  typedef struct packed {
    logic valid;
    logic sbe;
    logic dbe;
    logic collision;
  } rd_evt_s;

  typedef enum logic {
    ST_LOAD = 1'b0,
    ST_RUN = 1'b1
  } boot_state_e;

  typedef logic [15:0] sector_map_t;

endpackage

/* hdl/prot_region.sv */
// sector protection map from a protection register value
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_defs.svh"
module prot_region (
  // protection value
  input wire logic [7:0] prot_i,
  // one bit per sector, high when protected
  output flash_prot_pkg::sector_map_t map_o
);

  // sizes only grow with the code, so a larger code never shrinks a range
  function automatic logic [4:0] size_of(input logic [1:0] code);
    unique case (code)
      2'b00: size_of = `SIZE_CODE0;
      2'b01: size_of = `SIZE_CODE1;
      2'b10: size_of = `SIZE_CODE2;
      2'b11: size_of = `SIZE_CODE3;
    endcase
  endfunction

  logic [4:0] lo_n;
  logic [4:0] hi_n;
  assign lo_n = size_of(prot_i[`BIT_LOW_SIZE_HI:`BIT_LOW_SIZE_LO]);
  assign hi_n = size_of(prot_i[`BIT_HIGH_SIZE_HI:`BIT_HIGH_SIZE_LO]);

  for (genvar s = 0; s < `SECTOR_COUNT; s++) begin : g_sector
    logic in_lo;
    logic in_hi;
    logic in_rng;
    assign in_lo = !prot_i[`BIT_LOW_DISABLE] && (5'(s) < lo_n);
    assign in_hi = !prot_i[`BIT_HIGH_DISABLE] && (5'(s) >= 5'(`SECTOR_COUNT) - hi_n);
    assign in_rng = in_lo | in_hi;
    assign map_o[s] = prot_i[`BIT_POLARITY] ? in_rng : !in_rng;
  end

endmodule // prot_region
`default_nettype wire

/* tb/flash_fault_and_protection_regs_tb_top.sv */
// self-checking bench for the flash fault and protection register block
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_defs.svh"
module flash_fault_and_protection_regs_tb_top;
  localparam logic [11:0] addr_fault = {2'b00, `IDX_FAULT_STATUS, 2'b00};
  localparam logic [11:0] addr_prot = {2'b00, `IDX_SECTOR_PROTECT, 2'b00};
  localparam logic [11:0] addr_cfg = {2'b00, `IDX_FLASH_CONFIG, 2'b00};
  localparam logic [11:0] addr_stat = {2'b00, `IDX_FLASH_STATUS, 2'b00};
  // event codes, fields {valid, sbe, dbe, collision}
  localparam flash_prot_pkg::rd_evt_s ev_dbe = 4'ha;
  localparam flash_prot_pkg::rd_evt_s ev_sbe = 4'hc;
  localparam flash_prot_pkg::rd_evt_s ev_coll = 4'h9;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [7:0] nv_prot_byte_i = 8'hff;
  flash_prot_pkg::rd_evt_s rd_evt_i = '0;
  logic cmd_req_i = 1'b0;
  flash_prot_pkg::cmd_s cmd_i = '0;
  logic cmd_grant_o;
  logic cmd_refuse_o;
  logic prot_viol_o;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  flash_fault_and_protection_regs u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .nv_prot_byte_i(nv_prot_byte_i), .rd_evt_i(rd_evt_i),
    .cmd_req_i(cmd_req_i), .cmd_i(cmd_i), .cmd_grant_o(cmd_grant_o),
    .cmd_refuse_o(cmd_refuse_o), .prot_viol_o(prot_viol_o)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang ends the run through the same report
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 5000) begin
      error_cnt++;
      $display("MISMATCH timeout expected 0 seen %0d", cycles);
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic do_reset(input logic [7:0] nv);
    resetn_i <= 1'b0;
    nv_prot_byte_i <= nv;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    // first edge after release only loads the nonvolatile byte
    repeat (2) @(posedge clk_i);
  endtask

  // apb transfer; ev is presented so that it lands on the edge that completes the write
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err, input flash_prot_pkg::rd_evt_s ev);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
      rd_evt_i <= ev;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    rd_evt_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err = 1'b0,
                    input flash_prot_pkg::rd_evt_s ev = '0);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e, ev);
    chk("write pslverr", {31'h0, exp_err}, {31'h0, e});
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                      input logic exp_err = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e, '0);
    chk(nm, exp, r);
    chk({nm, " pslverr"}, {31'h0, exp_err}, {31'h0, e});
  endtask

  // answer is checked in the one cycle it stands
  task automatic cmd(input flash_prot_pkg::cmd_kind_e k, input logic [14:0] a, input logic g,
                     input logic v);
    cmd_req_i <= 1'b1;
    cmd_i <= '{kind: k, addr: a};
    @(posedge clk_i);
    cmd_req_i <= 1'b0;
    @(posedge clk_i);
    chk("cmd_grant", {31'h0, g}, {31'h0, cmd_grant_o});
    chk("cmd_refuse", {31'h0, !g}, {31'h0, cmd_refuse_o});
    chk("prot_viol", {31'h0, v}, {31'h0, prot_viol_o});
  endtask

  task automatic evt(input flash_prot_pkg::rd_evt_s x);
    rd_evt_i <= x;
    @(posedge clk_i);
    rd_evt_i <= '0;
    @(posedge clk_i);
  endtask

  initial begin
    // polarity one, both ranges off: nothing protected yet
    do_reset(8'he4);
    rchk("prot reset", addr_prot, 32'he4);
    rchk("fault reset", addr_fault, 32'h0);
    rchk("unmapped", 12'h030, 32'h0, 1'b1);
    rchk("misaligned", 12'h021, 32'h0, 1'b1);
    wr(12'h420, 32'hff, 1'b1);
    wr(addr_prot, 32'hbd);
    rchk("prot sizes", addr_prot, 32'hfd);
    wr(addr_prot, 32'hf9);
    rchk("prot low on", addr_prot, 32'hf9);
    wr(addr_prot, 32'hfd);
    rchk("prot no shrink", addr_prot, 32'hf9);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h0800, 1'b0, 1'b1);
    rchk("viol status", addr_stat, 32'h10);
    for (int k = 0; k < 4; k++) cmd(flash_prot_pkg::cmd_kind_e'(k), 15'h2800, 1'b0, 1'b1);
    wr(addr_stat, 32'h10);
    rchk("viol cleared", addr_stat, 32'h0);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h1000, 1'b1, 1'b0);
    cmd(flash_prot_pkg::CMD_ERASE_SECTOR, 15'h07ff, 1'b0, 1'b1);
    wr(addr_stat, 32'h10);
    cmd(flash_prot_pkg::CMD_ERASE_BLOCK, 15'h2800, 1'b0, 1'b1);
    wr(addr_stat, 32'h10);
    cmd(flash_prot_pkg::CMD_SEQ_START, 15'h0000, 1'b1, 1'b0);
    wr(addr_prot, 32'hd9);
    rchk("prot high on", addr_prot, 32'hd9);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h7fff, 1'b0, 1'b1);
    wr(addr_stat, 32'h10);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h3800, 1'b1, 1'b0);
    end_test("polarity one");
    evt(ev_dbe);
    rchk("double flag", addr_fault, 32'h02);
    wr(addr_fault, 32'h01);
    rchk("double keeps", addr_fault, 32'h02);
    wr(addr_fault, 32'h02, 1'b0, ev_dbe);
    rchk("set beats clear", addr_fault, 32'h02);
    wr(addr_fault, 32'hff);
    rchk("double clear", addr_fault, 32'h0);
    evt(ev_sbe);
    rchk("single flag", addr_fault, 32'h01);
    wr(addr_fault, 32'hfe);
    rchk("single keeps", addr_fault, 32'h01);
    wr(addr_fault, 32'h01);
    rchk("single clear", addr_fault, 32'h0);
    evt(ev_coll);
    rchk("collision", addr_fault, 32'h03);
    wr(addr_fault, 32'h03);
    wr(addr_cfg, 32'hff);
    rchk("config", addr_cfg, 32'h10);
    evt(ev_sbe);
    rchk("single ignored", addr_fault, 32'h0);
    evt(ev_coll);
    rchk("collision ignored", addr_fault, 32'h02);
    wr(addr_fault, 32'h03);
    wr(addr_cfg, 32'h0);
    end_test("fault flags");
    // a reset reloads the stored byte, so the upper sector is open again
    do_reset(8'he4);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h7fff, 1'b1, 1'b0);
    // polarity zero: sectors 0..7 and 14..15 open, 8..13 protected
    do_reset(8'h4b);
    rchk("prot reload", addr_prot, 32'h4b);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h1800, 1'b1, 1'b0);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h7fff, 1'b1, 1'b0);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h4800, 1'b0, 1'b1);
    wr(addr_stat, 32'h10);
    // size moves below would grow protection, so only the disable bit blocks them
    wr(addr_prot, 32'h43);
    rchk("high size locked", addr_prot, 32'h4b);
    wr(addr_prot, 32'h48);
    rchk("low size locked", addr_prot, 32'h4b);
    wr(addr_prot, 32'h6b);
    rchk("high off", addr_prot, 32'h6b);
    cmd(flash_prot_pkg::CMD_PROGRAM, 15'h7fff, 1'b0, 1'b1);
    wr(addr_stat, 32'h10);
    wr(addr_prot, 32'heb);
    rchk("polarity no shrink", addr_prot, 32'h6b);
    end_test("polarity zero");
    test_done();
  end
endmodule // flash_fault_and_protection_regs_tb_top
`default_nettype wire
